// >>> csg_cfg.svh
// constants for the current sense gain register: offsets, fields, values
`ifndef CSG_CFG_SVH
`define CSG_CFG_SVH

// ==========================================================================
// command code of the gain register
`define CSG_CMD_CODE 8'h38

// ==========================================================================
// field positions inside the 16-bit word (high byte is bits 15:8)
`define CSG_EXP_MSB 15
`define CSG_EXP_LSB 11
`define CSG_MANT_MSB 10
`define CSG_MANT_LSB 0
`define CSG_HIGH_MANT_MSB 2

// ==========================================================================
// fixed exponent and mantissa limits
`define CSG_EXP_VALUE 5'h10
`define CSG_MANT_RESET 11'h020
`define CSG_MANT_MIN 11'h010
`define CSG_MANT_MAX 11'h1fc

// ==========================================================================
// one mantissa step in nano-ohms
`define CSG_STEP_NANO_OHM 24'h003b9c

// ==========================================================================
// page select codes
`define CSG_PAGE_CH1 2'h0
`define CSG_PAGE_CH2 2'h1
`define CSG_PAGE_BOTH 2'h3

// ==========================================================================
// channel write masks
`define CSG_MASK_CH1 2'h1
`define CSG_MASK_CH2 2'h2
`define CSG_MASK_BOTH 2'h3

// ==========================================================================
// reply byte for reads past the end of the word
`define CSG_FILL_BYTE 8'hff

`endif

// >>> csg_gain_scale.sv
// converts effective mantissas into gain in nano-ohms per channel
`timescale 1ns/1ps
`include "csg_cfg.svh"

module csg_gain_scale (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // effective mantissas
  input wire csg_pkg::csg_mant_t eff_mant [2],
  // gain per channel in nano-ohms
  output csg_pkg::csg_gain_t gain_nohm [2]
);

  // ==========================================================================
  // gain = mantissa times step; stored values are never negative
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    always_ff @(posedge clock) begin
      if (rst) begin
        gain_nohm[ch] <= 24'h000000;
      end else begin
        gain_nohm[ch] <= 24'(24'(eff_mant[ch]) * `CSG_STEP_NANO_OHM);
      end
    end
  end

endmodule

// >>> csg_host_model.sv
// pmbus host model issuing byte events for word reads and writes
`timescale 1ns/1ps

module csg_host_model (
  // clock
  input wire logic clock,
  // answers from the register
  input wire logic ack_valid,
  input wire logic ack,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  // byte events toward the register
  output csg_pkg::csg_rx_s rx
);
  // idle bus at time zero
  initial rx = '0;

  // one byte event; kind 0 command, 1 data, 2 read request, 3 stop
  // released data shows the inverse so a stale byte is never mistaken
  task automatic xfer(input logic [1:0] k, input logic [7:0] d,
                      output logic ok, output logic [7:0] td);
    @(posedge clock);
    rx <= '{cmd_start: k == 2'h0, rx_valid: k == 2'h1, rx_data: d,
            tx_req: k == 2'h2, stop: k == 2'h3};
    @(posedge clock);
    rx <= '{rx_data: ~d, default: 1'b0};
    #1;
    ok = (k == 2'h2) ? tx_valid : (ack_valid && ack);
    td = tx_valid ? tx_data : 8'hxx;
  endtask

  // word write, low byte first; acks are command, low, high
  task automatic write_word(input logic [15:0] w, output logic [2:0] acks);
    logic ok;
    logic [7:0] td;
    xfer(2'h0, 8'h38, acks[2], td);
    xfer(2'h1, w[7:0], acks[1], td);
    xfer(2'h1, w[15:8], acks[0], td);
    xfer(2'h3, 8'h00, ok, td);
  endtask

  // word read, low byte arrives first
  task automatic read_word(output logic [15:0] w);
    logic ok;
    logic [7:0] td;
    xfer(2'h0, 8'h38, ok, td);
    xfer(2'h2, 8'h00, ok, w[7:0]);
    xfer(2'h2, 8'h00, ok, w[15:8]);
    xfer(2'h3, 8'h00, ok, td);
  endtask
endmodule

// >>> csg_page_store.sv
// per-channel mantissa store with user copies and effective values
`timescale 1ns/1ps
`include "csg_cfg.svh"

module csg_page_store (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // write and settings
  input wire csg_pkg::csg_wr_s wr,
  input wire logic store_user,
  input wire logic restore_user,
  input wire logic ch2_slave,
  // effective mantissas, index 0 is channel 1
  output csg_pkg::csg_mant_t eff_mant [2]
);

  csg_pkg::csg_mant_t mant_ff [2];
  csg_pkg::csg_mant_t user_ff [2];

  // ==========================================================================
  // stored and saved copies, one per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    // restore beats a write in the same cycle so a restore is never partial
    always_ff @(posedge clock) begin
      if (rst) begin
        mant_ff[ch] <= `CSG_MANT_RESET;
      end else if (restore_user) begin
        mant_ff[ch] <= user_ff[ch];
      end else if (wr.en && wr.ch_mask[ch]) begin
        mant_ff[ch] <= wr.mant;
      end
    end

    // saved user value; the nonvolatile copy itself lives elsewhere
    always_ff @(posedge clock) begin
      if (rst) begin
        user_ff[ch] <= `CSG_MANT_RESET;
      end else if (store_user) begin
        user_ff[ch] <= mant_ff[ch];
      end
    end
  end

  // ==========================================================================
  // a slave channel 2 runs on the channel 1 gain
  always_ff @(posedge clock) begin
    if (rst) begin
      eff_mant[0] <= `CSG_MANT_RESET;
      eff_mant[1] <= `CSG_MANT_RESET;
    end else begin
      eff_mant[0] <= mant_ff[0];
      eff_mant[1] <= ch2_slave ? mant_ff[0] : mant_ff[1];
    end
  end

endmodule

// >>> csg_pkg.sv
// types shared by the current sense gain register modules
package csg_pkg;

  // ========================================================================
  // field types
  typedef logic [10:0] csg_mant_t;
  typedef logic [23:0] csg_gain_t;

  // ========================================================================
  // byte events from the pmbus transaction layer
  typedef struct packed {
    logic cmd_start;
    logic rx_valid;
    logic [7:0] rx_data;
    logic tx_req;
    logic stop;
  } csg_rx_s;

  // ========================================================================
  // committed write toward the per-channel store
  typedef struct packed {
    logic en;
    logic [1:0] ch_mask;
    csg_mant_t mant;
  } csg_wr_s;

  // ========================================================================
  // transaction states, one-hot
  typedef enum logic [5:0] {
    CSG_ST_IDLE = 6'h01,
    CSG_ST_CMD = 6'h02,
    CSG_ST_LOW = 6'h04,
    CSG_ST_DONE = 6'h08,
    CSG_ST_REFUSED = 6'h10,
    CSG_ST_READ = 6'h20
  } csg_state_e;

endpackage

// >>> csg_top.sv
// current sense gain register: pmbus word access, paging and protection
`timescale 1ns/1ps
`include "csg_cfg.svh"

module csg_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // byte events from the pmbus transaction layer
  input wire csg_pkg::csg_rx_s rx,
  // page select and phase configuration
  input wire logic [1:0] page_sel,
  input wire logic ch2_slave,
  // user settings and fault clearing
  input wire logic store_user,
  input wire logic restore_user,
  input wire logic clear_faults,
  // byte answers
  output logic ack_valid,
  output logic ack,
  output logic tx_valid,
  output logic [7:0] tx_data,
  // fault flags and alert
  output logic invalid_command_fault,
  output logic invalid_data_fault,
  output logic smbalert_n,
  // effective gain per channel, index 0 is channel 1
  output csg_pkg::csg_mant_t gain_mant [2],
  output csg_pkg::csg_gain_t gain_nohm [2]
);

  // ==========================================================================
  // declarations
  csg_pkg::csg_state_e state_ff;
  csg_pkg::csg_state_e nxt_state;
  logic [7:0] low_ff;
  logic [7:0] nxt_low;
  csg_pkg::csg_wr_s wr_ff;
  csg_pkg::csg_wr_s nxt_wr;
  logic ack_valid_ff;
  logic nxt_ack_valid;
  logic ack_ff;
  logic nxt_ack;
  logic tx_valid_ff;
  logic nxt_tx_valid;
  logic [7:0] tx_data_ff;
  logic [7:0] nxt_tx_data;
  logic [15:0] rd_word_ff;
  logic [15:0] nxt_rd_word;
  logic rd_high_ff;
  logic nxt_rd_high;
  logic rd_past_ff;
  logic nxt_rd_past;
  logic cmd_fault_ff;
  logic nxt_cmd_fault;
  logic ivd_ff;
  logic nxt_ivd;
  logic alert_n_ff;
  logic set_cmd_fault;
  logic set_ivd;
  logic page_refused;
  logic [1:0] page_mask;
  csg_pkg::csg_mant_t wr_mant;
  logic mant_in_range;
  csg_pkg::csg_mant_t rd_mant;
  logic [15:0] rd_word_now;

  // ==========================================================================
  // page decode
  // a slave channel 2 on page 11 still follows channel 1, so the write
  // goes to channel 1 only and is not treated as a refusal
  always_comb begin
    page_refused = 1'b0;
    page_mask = `CSG_MASK_CH1;
    unique case (page_sel)
      `CSG_PAGE_CH1: begin
        page_mask = `CSG_MASK_CH1;
      end
      `CSG_PAGE_CH2: begin
        page_mask = `CSG_MASK_CH2;
        page_refused = ch2_slave;
      end
      `CSG_PAGE_BOTH: begin
        page_mask = ch2_slave ? `CSG_MASK_CH1 : `CSG_MASK_BOTH;
      end
      default: begin
        page_refused = 1'b1; // code 10 names no page
      end
    endcase
  end

  // ==========================================================================
  // mantissa assembled from the high byte and the held low byte
  // exponent bits of the high byte are simply not looked at
  assign wr_mant = {rx.rx_data[`CSG_HIGH_MANT_MSB:0], low_ff};
  // a set sign bit reads as a large unsigned value and therefore above the maximum
  assign mant_in_range = (wr_mant >= `CSG_MANT_MIN) &&
                         (wr_mant <= `CSG_MANT_MAX);

  // ==========================================================================
  // read word of the selected page; a slave channel 2 shows channel 1
  assign rd_mant = (page_sel == `CSG_PAGE_CH2) ? gain_mant[1] : gain_mant[0];
  assign rd_word_now = {`CSG_EXP_VALUE, rd_mant};

  // ==========================================================================
  // transaction sequencer
  // a new command byte beats a stop in the same cycle: that is a
  // repeated start, and the old transfer is over either way
  always_comb begin
    nxt_state = state_ff;
    nxt_low = low_ff;
    nxt_wr = '0;
    nxt_ack_valid = 1'b0;
    nxt_ack = ack_ff;
    nxt_tx_valid = 1'b0;
    nxt_tx_data = tx_data_ff;
    nxt_rd_word = rd_word_ff;
    nxt_rd_high = rd_high_ff;
    nxt_rd_past = rd_past_ff;
    set_cmd_fault = 1'b0;
    set_ivd = 1'b0;
    if (rx.cmd_start) begin
      nxt_rd_high = 1'b0;
      nxt_rd_past = 1'b0;
      if (rx.rx_data == `CSG_CMD_CODE) begin
        nxt_state = csg_pkg::CSG_ST_CMD;
        nxt_ack_valid = 1'b1;
        nxt_ack = 1'b1;
      end else begin
        nxt_state = csg_pkg::CSG_ST_IDLE; // other commands are not ours
      end
    end else if (rx.stop) begin
      nxt_state = csg_pkg::CSG_ST_IDLE; // a half word is dropped here
    end else begin
      unique case (state_ff)
        csg_pkg::CSG_ST_IDLE: begin
          nxt_state = csg_pkg::CSG_ST_IDLE;
        end
        csg_pkg::CSG_ST_CMD: begin
          if (rx.rx_valid) begin
            nxt_ack_valid = 1'b1;
            if (page_refused) begin
              nxt_ack = 1'b0;
              set_cmd_fault = 1'b1;
              nxt_state = csg_pkg::CSG_ST_REFUSED;
            end else begin
              nxt_ack = 1'b1;
              nxt_low = rx.rx_data;
              nxt_state = csg_pkg::CSG_ST_LOW;
            end
          end else if (rx.tx_req) begin
            // snapshot so both bytes belong to one word
            nxt_rd_word = rd_word_now;
            nxt_tx_valid = 1'b1;
            nxt_tx_data = rd_word_now[7:0];
            nxt_rd_high = 1'b1;
            nxt_state = csg_pkg::CSG_ST_READ;
          end
        end
        csg_pkg::CSG_ST_LOW: begin
          if (rx.rx_valid) begin
            nxt_ack_valid = 1'b1;
            nxt_state = csg_pkg::CSG_ST_DONE;
            if (mant_in_range) begin
              nxt_ack = 1'b1;
              nxt_wr.en = 1'b1;
              nxt_wr.ch_mask = page_mask;
              nxt_wr.mant = wr_mant;
            end else begin
              nxt_ack = 1'b0;
              set_ivd = 1'b1;
            end
          end
        end
        csg_pkg::CSG_ST_DONE: begin
          if (rx.rx_valid) begin
            nxt_ack_valid = 1'b1;
            nxt_ack = 1'b0; // bytes beyond the word
          end
        end
        csg_pkg::CSG_ST_REFUSED: begin
          if (rx.rx_valid) begin
            nxt_ack_valid = 1'b1;
            nxt_ack = 1'b0;
          end
        end
        csg_pkg::CSG_ST_READ: begin
          if (rx.tx_req) begin
            nxt_tx_valid = 1'b1;
            if (rd_high_ff && !rd_past_ff) begin
              nxt_tx_data = rd_word_ff[15:8];
              nxt_rd_past = 1'b1;
            end else begin
              nxt_tx_data = `CSG_FILL_BYTE;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // sequencer state
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= csg_pkg::CSG_ST_IDLE;
      low_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      low_ff <= nxt_low;
    end
  end

  // ==========================================================================
  // read snapshot and byte position
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_word_ff <= 16'h0000;
      rd_high_ff <= 1'b0;
      rd_past_ff <= 1'b0;
    end else begin
      rd_word_ff <= nxt_rd_word;
      rd_high_ff <= nxt_rd_high;
      rd_past_ff <= nxt_rd_past;
    end
  end

  // ==========================================================================
  // committed write, a one-cycle pulse toward the store
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
    end
  end

  // ==========================================================================
  // byte answers
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_valid_ff <= 1'b0;
      ack_ff <= 1'b0;
      tx_valid_ff <= 1'b0;
      tx_data_ff <= 8'h00;
    end else begin
      ack_valid_ff <= nxt_ack_valid;
      ack_ff <= nxt_ack;
      tx_valid_ff <= nxt_tx_valid;
      tx_data_ff <= nxt_tx_data;
    end
  end

  // ==========================================================================
  // sticky faults; a new fault beats a clear in the same cycle
  always_comb begin
    nxt_cmd_fault = cmd_fault_ff;
    nxt_ivd = ivd_ff;
    if (clear_faults) begin
      nxt_cmd_fault = 1'b0;
      nxt_ivd = 1'b0;
    end
    if (set_cmd_fault) begin
      nxt_cmd_fault = 1'b1;
    end
    if (set_ivd) begin
      nxt_ivd = 1'b1;
    end
  end

  // alert follows the flags in the same edge, so it never lags them
  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_fault_ff <= 1'b0;
      ivd_ff <= 1'b0;
      alert_n_ff <= 1'b1;
    end else begin
      cmd_fault_ff <= nxt_cmd_fault;
      ivd_ff <= nxt_ivd;
      alert_n_ff <= !(nxt_cmd_fault || nxt_ivd);
    end
  end

  // ==========================================================================
  // per-channel store and gain scaling
  csg_page_store u_store (
    .clock(clock),
    .rst(rst),
    .wr(wr_ff),
    .store_user(store_user),
    .restore_user(restore_user),
    .ch2_slave(ch2_slave),
    .eff_mant(gain_mant)
  );

  // gain in nano-ohm units for the current measurement path
  csg_gain_scale u_scale (
    .clock(clock),
    .rst(rst),
    .eff_mant(gain_mant),
    .gain_nohm(gain_nohm)
  );

  // ==========================================================================
  // outputs, all from flip-flops
  assign ack_valid = ack_valid_ff;
  assign ack = ack_ff;
  assign tx_valid = tx_valid_ff;
  assign tx_data = tx_data_ff;
  assign invalid_command_fault = cmd_fault_ff;
  assign invalid_data_fault = ivd_ff;
  assign smbalert_n = alert_n_ff;

endmodule

// >>> csg_top_asserts.sv
// checker for the current sense gain register ports
`timescale 1ns/1ps

module csg_top_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // byte events
  input wire csg_pkg::csg_rx_s rx,
  input wire logic ch2_slave,
  input wire logic clear_faults,
  // answers and flags
  input wire logic ack_valid,
  input wire logic ack,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic invalid_command_fault,
  input wire logic invalid_data_fault,
  input wire logic smbalert_n,
  // effective gain
  input wire csg_pkg::csg_mant_t gain_mant [2],
  input wire csg_pkg::csg_gain_t gain_nohm [2]
);
  // ========================================================================
  // read byte counter, restarted by every command byte
  logic [1:0] tx_cnt_ff;

  // counts answered read bytes so the high byte can be picked out
  always_ff @(posedge clock) begin
    if (rst || rx.cmd_start) begin
      tx_cnt_ff <= 2'h0;
    end else if (tx_valid && tx_cnt_ff != 2'h3) begin
      tx_cnt_ff <= tx_cnt_ff + 2'h1;
    end
  end

  // ========================================================================
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_alert_tracks_flags: assert property (
    smbalert_n == !(invalid_command_fault || invalid_data_fault))
    else $error("alert does not follow the fault flags");
  a_cmd_fault_nack: assert property (
    $rose(invalid_command_fault) |-> ack_valid && !ack)
    else $error("command fault without a nack");
  a_cmd_fault_sticky: assert property (
    invalid_command_fault && !clear_faults |=> invalid_command_fault)
    else $error("command fault dropped without clear");
  a_ivd_with_nack: assert property (
    $rose(invalid_data_fault) |-> ack_valid && !ack)
    else $error("data fault without a nack");
  a_mant_in_range: assert property (
    gain_mant[0] >= 11'h010 && gain_mant[0] <= 11'h1fc)
    else $error("mantissa outside its range");
  a_slave_copy_gain: assert property (
    ch2_slave && $past(ch2_slave) |-> gain_mant[1] == gain_mant[0])
    else $error("slave channel does not use channel 1 gain");
  a_scale_gain_step: assert property (
    !$past(rst) |-> gain_nohm[0] == $past(gain_mant[0]) * 24'h003b9c)
    else $error("gain not mantissa times step");
  a_cmd_ack_next: assert property (
    rx.cmd_start && rx.rx_data == 8'h38 |=> ack_valid && ack)
    else $error("own command code not acked next cycle");
  a_read_exp_fixed: assert property (
    tx_valid && tx_cnt_ff == 2'h1 |-> tx_data[7:3] == 5'h10)
    else $error("high read byte lacks fixed exponent");

  c_cmd_fault: cover property ($rose(invalid_command_fault));
  c_ivd: cover property ($rose(invalid_data_fault));
  c_high_read: cover property (tx_valid && tx_cnt_ff == 2'h1);
endmodule

bind csg_top csg_top_asserts csg_top_asserts_i (
  .clock(clock), .rst(rst), .rx(rx), .ch2_slave(ch2_slave),
  .clear_faults(clear_faults), .ack_valid(ack_valid), .ack(ack),
  .tx_valid(tx_valid), .tx_data(tx_data),
  .invalid_command_fault(invalid_command_fault),
  .invalid_data_fault(invalid_data_fault), .smbalert_n(smbalert_n),
  .gain_mant(gain_mant), .gain_nohm(gain_nohm)
);

// >>> csg_top_tb.sv
// testbench for the current sense gain register
`timescale 1ns/1ps

module csg_top_tb;
  // ========================================================================
  // signals
  logic clock, rst, ch2_slave, ack_valid, ack, tx_valid;
  logic cmd_fault, data_fault, smbalert_n;
  logic [1:0] page_sel;
  logic [2:0] pulse_v, acks;
  logic [7:0] tx_data;
  logic [15:0] word;
  csg_pkg::csg_rx_s rx;
  csg_pkg::csg_mant_t gain_mant [2];
  csg_pkg::csg_gain_t gain_nohm [2];
  int fail_count, comparisons;

  // ========================================================================
  // design and host
  csg_top csg_top_i (.clock(clock), .rst(rst), .rx(rx),
    .page_sel(page_sel), .ch2_slave(ch2_slave),
    .store_user(pulse_v[2]), .restore_user(pulse_v[1]),
    .clear_faults(pulse_v[0]), .ack_valid(ack_valid), .ack(ack),
    .tx_valid(tx_valid), .tx_data(tx_data),
    .invalid_command_fault(cmd_fault), .invalid_data_fault(data_fault),
    .smbalert_n(smbalert_n), .gain_mant(gain_mant),
    .gain_nohm(gain_nohm));
  csg_host_model csg_host_model_i (.clock(clock), .ack_valid(ack_valid),
    .ack(ack), .tx_valid(tx_valid), .tx_data(tx_data), .rx(rx));

  // 125 mhz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ========================================================================
  // tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic pulse(input logic [2:0] p);
    @(posedge clock);
    pulse_v <= p;
    @(posedge clock);
    pulse_v <= 3'h0;
  endtask

  task automatic wr(input logic [1:0] p, input logic [15:0] w,
                    input logic [2:0] e);
    @(posedge clock);
    page_sel <= p;
    csg_host_model_i.write_word(w, acks);
    chk({21'h0, acks}, {21'h0, e});
  endtask

  task automatic rd(input logic [1:0] p, input logic [15:0] e);
    @(posedge clock);
    page_sel <= p;
    csg_host_model_i.read_word(word);
    chk({8'h0, word}, {8'h0, e});
  endtask

  // flags are {command fault, data fault, alert}
  task automatic flags(input logic [2:0] e);
    chk({21'h0, cmd_fault, data_fault, smbalert_n}, {21'h0, e});
  endtask

  task automatic final_report;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog; the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    final_report;
  end

  // ========================================================================
  // test sequence
  initial begin
    rst = 1'b1;
    page_sel = 2'h0;
    ch2_slave = 1'b0;
    pulse_v = 3'h0;
    fail_count = 0;
    comparisons = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    tick(2);
    chk(gain_nohm[0], 24'(32 * 15260));
    rd(2'h0, 16'h8020);
    rd(2'h1, 16'h8020);
    // exponent bits written as 01010 must be dropped
    wr(2'h0, 16'h51fc, 3'h7);
    tick(2);
    chk(gain_nohm[0], 24'(508 * 15260));
    rd(2'h0, 16'h81fc);
    rd(2'h1, 16'h8020);
    wr(2'h0, 16'h000f, 3'h6);
    flags(3'h2);
    wr(2'h0, 16'h01fd, 3'h6);
    wr(2'h0, 16'h0010, 3'h7);
    rd(2'h0, 16'h8010);
    pulse(3'h1);
    tick(1);
    flags(3'h1);
    // page code 10 names no channel and is refused like a slave page
    wr(2'h2, 16'h0040, 3'h4);
    flags(3'h4);
    pulse(3'h1);
    // another command code is not ours and gets no answer
    csg_host_model_i.xfer(2'h0, 8'h39, acks[0], word[7:0]);
    chk({23'h0, acks[0]}, 24'h000000);
    csg_host_model_i.xfer(2'h3, 8'h00, acks[0], word[7:0]);
    wr(2'h1, 16'h0040, 3'h7);
    tick(1);
    chk(gain_nohm[1], 24'(64 * 15260));
    rd(2'h1, 16'h8040);
    rd(2'h0, 16'h8010);
    wr(2'h3, 16'h0100, 3'h7);
    rd(2'h0, 16'h8100);
    rd(2'h1, 16'h8100);
    // channel 2 becomes a slave: its page refuses writes
    @(posedge clock);
    ch2_slave <= 1'b1;
    wr(2'h1, 16'h0080, 3'h4);
    flags(3'h4);
    wr(2'h0, 16'h0030, 3'h7);
    tick(1);
    chk({13'h0, gain_mant[1]}, 24'h000030);
    rd(2'h1, 16'h8030);
    // saved values come back over a later write
    pulse(3'h4);
    wr(2'h0, 16'h0050, 3'h7);
    pulse(3'h2);
    tick(1);
    rd(2'h0, 16'h8030);
    // a stacked controller takes over the master gain it just read
    wr(2'h0, word, 3'h7);
    @(posedge clock);
    ch2_slave <= 1'b0;
    rd(2'h1, 16'h8100);
    // second reset in mid-run
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    tick(2);
    flags(3'h1);
    rd(2'h0, 16'h8020);
    // the companion power stage wants half a milliohm, mantissa 32
    wr(2'h0, 16'h0020, 3'h7);
    rd(2'h0, 16'h8020);
    final_report;
  end
endmodule
